// file: logic/dcc_pkg.sv
package dcc_pkg;
	// register byte addresses on the AHB-Lite slave
	localparam logic [7:0] ADDR_PER_ENABLE = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_FILTER = 8'h08;
	localparam logic [7:0] ADDR_OUTCTL = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_FLAG = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [7:0] ADDR_IRQ_PRIO = 8'h18;
	localparam logic [7:0] ADDR_RAW = 8'h1c;
	localparam int ADDR_W = 8;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// peripheral enable: clock gate bit
	localparam int PER_GATE_BIT = 5;
	// mode register fields, comparator i at offset 4*i
	localparam int MODE_ENB = 0;
	localparam int MODE_WDE = 1;
	localparam int MODE_VRF = 2;
	localparam int MODE_MON = 3;
	localparam int MODE_STRIDE = 4;
	// filter register fields, comparator i at offset 4*i
	localparam int FIR_FCK_LO = 0;
	localparam int FIR_EPO = 2;
	localparam int FIR_EDG = 3;
	localparam int FIR_STRIDE = 4;
	// output control fields, comparator i at offset 3*i
	localparam int OCR_IE = 0;
	localparam int OCR_OE = 1;
	localparam int OCR_OP = 2;
	localparam int OCR_STRIDE = 3;
	localparam int OCR_SPEED = 7;
	localparam logic [7:0] OCR_WMASK = 8'hbf;
	// irq flag bits: comparator 1 at bit 7, comparator 0 at bit 6
	localparam int IRQ_BIT0 = 6;
	localparam int IRQ_BIT1 = 7;
	// filter sampling dividers
	localparam int FILT_DIV_MID = 8;
	localparam int FILT_DIV_SLOW = 32;
	localparam logic [1:0] FCK_BYPASS = 2'b00;
	localparam logic [1:0] FCK_FULL = 2'b01;
	localparam logic [1:0] FCK_DIV8 = 2'b10;
	localparam int FILT_MATCHES = 3;
	typedef enum logic [1:0] {
		DCC_IDLE = 2'b00,
		DCC_DATA = 2'b01
	} dcc_bus_e;
endpackage

// file: logic/dcc_divider.sv
`timescale 1ns/1ps
module dcc_divider
	import dcc_pkg::*;
#(
	parameter int DIV_A = FILT_DIV_MID,
	parameter int DIV_B = FILT_DIV_SLOW
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic run,
	output logic tickA,
	output logic tickB
);
	typedef struct packed {
		logic [7:0] cnt;
		logic tickA;
		logic tickB;
	} dcc_div_s;
	dcc_div_s st_r, st_nxt;
	localparam logic [7:0] LAST_B = 8'(DIV_B - 1);
	localparam logic [7:0] MASK_A = 8'(DIV_A - 1);
	always_comb begin
		st_nxt = st_r;
		st_nxt.tickA = 1'b0;
		st_nxt.tickB = 1'b0;
		if (!run) begin
			st_nxt.cnt = 8'h00;
		end else begin
			st_nxt.cnt = (st_r.cnt == LAST_B) ? 8'h00 : st_r.cnt + 8'h01;
			st_nxt.tickA = (st_r.cnt & MASK_A) == MASK_A;
			st_nxt.tickB = st_r.cnt == LAST_B;
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign tickA = st_r.tickA;
	assign tickB = st_r.tickB;
endmodule // dcc_divider

// file: logic/dcc_channel.sv
`timescale 1ns/1ps
module dcc_channel
	import dcc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic gateOn,
	input wire logic enable,
	input wire logic rawResult,
	input wire logic [1:0] filterSel,
	input wire logic tickMid,
	input wire logic tickSlow,
	input wire logic bothEdge,
	input wire logic edgePolarity,
	input wire logic irqEnable,
	input wire logic outInvert,
	input wire logic outEnable,
	output logic monitor,
	output logic edgeEvent,
	output logic pinOut,
	output logic pinOe
);
	typedef struct packed {
		logic [FILT_MATCHES-1:0] hist;
		logic filtOut;
		logic prevLevel;
		logic monitor;
		logic edgeEvent;
		logic pinOut;
		logic pinOe;
	} dcc_ch_s;
	dcc_ch_s st_r, st_nxt;
	logic sample;
	logic level;
	always_comb begin
		case (filterSel)
			FCK_FULL: sample = 1'b1;
			FCK_DIV8: sample = tickMid;
			default: sample = tickSlow;
		endcase
		st_nxt = st_r;
		if (!gateOn) begin
			st_nxt = '0;
		end else begin
			if (filterSel != FCK_BYPASS && sample) begin
				// adopt level one sample after three matches
				if (&st_r.hist || ~|st_r.hist) begin
					st_nxt.filtOut = st_r.hist[0];
				end
				st_nxt.hist = {st_r.hist[FILT_MATCHES-2:0], rawResult};
			end
		end
		level = (filterSel == FCK_BYPASS) ? rawResult : st_r.filtOut;
		if (gateOn) begin
			st_nxt.prevLevel = level;
			// raw result already encodes standard or window comparison
			st_nxt.monitor = enable ? rawResult : 1'b0;
			st_nxt.edgeEvent = irqEnable && enable && (level != st_r.prevLevel) &&
				(bothEdge || (level ^ edgePolarity));
			st_nxt.pinOut = (rawResult ^ outInvert) & outEnable;
			st_nxt.pinOe = outEnable;
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign monitor = st_r.monitor;
	assign edgeEvent = st_r.edgeEvent;
	assign pinOut = st_r.pinOut;
	assign pinOe = st_r.pinOe;
endmodule // dcc_channel

// file: logic/dcc_top.sv
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module dcc_top
	import dcc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [1:0] compareResultIn,
	output logic [1:0] compare_result_pin,
	output logic [1:0] compareResultOe,
	output logic [1:0] compareIrq,
	output logic [1:0] windowModeOut,
	output logic [1:0] referenceSourceOut,
	output logic [1:0] comparatorEnableOut,
	output logic speedSelectOut
);
	typedef struct packed {
		dcc_bus_e phase;
		logic [ADDR_W-1:0] addr;
		logic wr;
		logic [31:0] rdata;
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [7:0] perEnable;
		logic [7:0] mode;
		logic [7:0] filter;
		logic [7:0] outCtl;
		logic [7:0] irqFlag;
		logic [7:0] irqMask;
		logic [15:0] irqPrio;
		logic [1:0] irqOut;
		logic [1:0] wde;
		logic [1:0] vrf;
		logic [1:0] enb;
		logic speed;
	} dcc_top_s;
	dcc_top_s st_r, st_nxt;
	logic gateOn;
	logic tickMid;
	logic tickSlow;
	logic [1:0] monitor;
	logic [1:0] edgeEvent;
	logic [1:0] pinOut;
	logic [1:0] pinOe;
	logic [7:0] modeRead;
	logic [7:0] wbyte;
	logic [7:0] irqSet;
	assign gateOn = st_r.perEnable[PER_GATE_BIT];

	// slower filter rates are single-cycle enables, not derived clocks
	dcc_divider #(
		.DIV_A(FILT_DIV_MID),
		.DIV_B(FILT_DIV_SLOW)
	) u_div (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.run(gateOn),
		.tickA(tickMid),
		.tickB(tickSlow)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ch
			dcc_channel u_ch (
				.sys_clk(sys_clk),
				.reset_n(reset_n),
				.gateOn(gateOn),
				.enable(st_r.mode[gi*MODE_STRIDE+MODE_ENB]),
				.rawResult(st_r.sync2[gi]),
				.filterSel(st_r.filter[gi*FIR_STRIDE+FIR_FCK_LO +: 2]),
				.tickMid(tickMid),
				.tickSlow(tickSlow),
				.bothEdge(st_r.filter[gi*FIR_STRIDE+FIR_EDG]),
				.edgePolarity(st_r.filter[gi*FIR_STRIDE+FIR_EPO]),
				.irqEnable(st_r.outCtl[gi*OCR_STRIDE+OCR_IE]),
				.outInvert(st_r.outCtl[gi*OCR_STRIDE+OCR_OP]),
				.outEnable(st_r.outCtl[gi*OCR_STRIDE+OCR_OE]),
				.monitor(monitor[gi]),
				.edgeEvent(edgeEvent[gi]),
				.pinOut(pinOut[gi]),
				.pinOe(pinOe[gi])
			);
		end
	endgenerate

	always_comb begin
		modeRead = st_r.mode;
		modeRead[MODE_MON] = monitor[0];
		modeRead[MODE_STRIDE+MODE_MON] = monitor[1];
		irqSet = 8'h00;
		irqSet[IRQ_BIT0] = edgeEvent[0];
		irqSet[IRQ_BIT1] = edgeEvent[1];
		wbyte = hwdata[7:0];
		st_nxt = st_r;
		// pin input synchroniser; only sync2 feeds logic
		st_nxt.sync1 = compareResultIn;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.phase = DCC_IDLE;
		st_nxt.wr = 1'b0;
		// set wins over clear in the flag register
		if (st_r.phase == DCC_DATA && st_r.wr) begin
			case (st_r.addr)
				ADDR_PER_ENABLE: st_nxt.perEnable = wbyte;
				ADDR_MODE: begin
					if (gateOn) begin
						st_nxt.mode = wbyte;
						st_nxt.mode[MODE_MON] = 1'b0;
						st_nxt.mode[MODE_STRIDE+MODE_MON] = 1'b0;
					end
				end
				ADDR_FILTER: if (gateOn) st_nxt.filter = wbyte;
				ADDR_OUTCTL: if (gateOn) st_nxt.outCtl = wbyte & OCR_WMASK;
				ADDR_IRQ_FLAG: st_nxt.irqFlag = wbyte;
				ADDR_IRQ_MASK: st_nxt.irqMask = wbyte;
				ADDR_IRQ_PRIO: st_nxt.irqPrio = hwdata[15:0];
				default: ;
			endcase
		end
		st_nxt.irqFlag = st_nxt.irqFlag | irqSet;
		if (!gateOn) begin
			st_nxt.mode = RESET_BYTE;
			st_nxt.filter = RESET_BYTE;
			st_nxt.outCtl = RESET_BYTE;
		end
		st_nxt.irqOut[0] = st_r.irqFlag[IRQ_BIT0] & ~st_r.irqMask[IRQ_BIT0];
		st_nxt.irqOut[1] = st_r.irqFlag[IRQ_BIT1] & ~st_r.irqMask[IRQ_BIT1];
		st_nxt.wde = {st_r.mode[MODE_STRIDE+MODE_WDE], st_r.mode[MODE_WDE]};
		st_nxt.vrf = {st_r.mode[MODE_STRIDE+MODE_VRF], st_r.mode[MODE_VRF]};
		st_nxt.enb = {st_r.mode[MODE_STRIDE+MODE_ENB], st_r.mode[MODE_ENB]};
		st_nxt.speed = st_r.outCtl[OCR_SPEED];
		if (hsel && hready && htrans[1]) begin
			st_nxt.phase = DCC_DATA;
			st_nxt.addr = haddr[ADDR_W-1:0];
			st_nxt.wr = hwrite;
			case (haddr[ADDR_W-1:0])
				ADDR_PER_ENABLE: st_nxt.rdata = {24'h000000, st_r.perEnable};
				ADDR_MODE: st_nxt.rdata = {24'h000000, modeRead};
				ADDR_FILTER: st_nxt.rdata = {24'h000000, st_r.filter};
				ADDR_OUTCTL: st_nxt.rdata = {24'h000000, st_r.outCtl};
				ADDR_IRQ_FLAG: st_nxt.rdata = {24'h000000, st_r.irqFlag};
				ADDR_IRQ_MASK: st_nxt.rdata = {24'h000000, st_r.irqMask};
				ADDR_IRQ_PRIO: st_nxt.rdata = {16'h0000, st_r.irqPrio};
				ADDR_RAW: st_nxt.rdata = {30'h0, st_r.sync2};
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
			st_r.irqMask <= 8'hff;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hrdata = st_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign compare_result_pin = pinOut;
	assign compareResultOe = pinOe;
	assign compareIrq = st_r.irqOut;
	assign windowModeOut = st_r.wde;
	assign referenceSourceOut = st_r.vrf;
	assign comparatorEnableOut = st_r.enb;
	assign speedSelectOut = st_r.speed;
endmodule // dcc_top

// file: verif/dcc_top_chk.sv
`timescale 1ns/1ps
module dcc_top_chk
	import dcc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [1:0] compare_result_pin,
	input wire logic [1:0] compareResultOe,
	input wire logic [1:0] compareIrq,
	input wire logic [1:0] windowModeOut,
	input wire logic [1:0] referenceSourceOut,
	input wire logic [1:0] comparatorEnableOut,
	input wire logic speedSelectOut
);
	import dcc_pkg::*;
	// shadow of the control registers, updated on the same edge as the block's own
	logic wS;
	logic gate;
	logic [7:0] aS, perS, modeS, ocrS, maskS;
	assign gate = perS[PER_GATE_BIT];
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			{wS, aS, perS, modeS, ocrS} <= '0;
			maskS <= 8'hff;
		end else begin
			wS <= hsel && hready && htrans[1] && hwrite;
			aS <= haddr[7:0];
			if (!gate) begin
				{modeS, ocrS} <= 16'h0000;
			end
			if (wS && aS == ADDR_PER_ENABLE) begin
				perS <= hwdata[7:0];
			end
			if (wS && gate && aS == ADDR_MODE) begin
				modeS <= hwdata[7:0];
			end
			if (wS && gate && aS == ADDR_OUTCTL) begin
				ocrS <= hwdata[7:0] & OCR_WMASK;
			end
			if (wS && aS == ADDR_IRQ_MASK) begin
				maskS <= hwdata[7:0];
			end
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_oe_follows: assert property (gate && $past(gate, 2) |->
		compareResultOe == $past({ocrS[4], ocrS[1]})) else $error("pin enable differs");
	a_pin_off: assert property ((compare_result_pin & ~compareResultOe) == 2'h0)
		else $error("pin driven while disabled");
	a_speed_shared: assert property (gate && $past(gate, 2) |->
		speedSelectOut == $past(ocrS[OCR_SPEED])) else $error("speed differs");
	a_enable_out: assert property (gate && $past(gate, 2) |->
		comparatorEnableOut == $past({modeS[4], modeS[0]})) else $error("enable differs");
	a_window_out: assert property (gate && $past(gate, 2) |->
		windowModeOut == $past({modeS[5], modeS[1]})) else $error("window differs");
	a_ref_out: assert property (gate && $past(gate, 2) |->
		referenceSourceOut == $past({modeS[6], modeS[2]})) else $error("reference differs");
	a_gate_clear: assert property (!gate && !$past(gate) |=>
		{comparatorEnableOut, compareResultOe, speedSelectOut} == 5'h00)
		else $error("state kept with gate off");
	a_irq_mask: assert property (compareIrq != 2'h0 |->
		(compareIrq & $past({maskS[IRQ_BIT1], maskS[IRQ_BIT0]})) == 2'h0)
		else $error("masked request seen");
endmodule // dcc_top_chk
bind dcc_top dcc_top_chk dcc_top_chk_i (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .compare_result_pin, .compareResultOe, .compareIrq, .windowModeOut,
	.referenceSourceOut, .comparatorEnableOut, .speedSelectOut);

// file: verif/dcc_analog_model.sv
`timescale 1ns/1ps
module dcc_analog_model #(
	parameter int REF_PIN = 100,
	parameter int REF_INT = 120,
	parameter int WIN_LO = 50,
	parameter int WIN_HI = 150
) (
	input wire logic [7:0] vin0,
	input wire logic [7:0] vin1,
	input wire logic [1:0] winMode,
	input wire logic [1:0] refSel,
	input wire logic [1:0] enable,
	output logic [1:0] result
);
	// a stopped comparator reports low, as the front end would
	function automatic logic decide(int v, logic w, logic r, logic e);
		if (!e) return 1'h0;
		if (w) return v > WIN_LO && v < WIN_HI;
		return v > (r ? REF_INT : REF_PIN);
	endfunction
	assign result = {decide(vin1, winMode[1], refSel[1], enable[1]),
		decide(vin0, winMode[0], refSel[0], enable[0])};
endmodule // dcc_analog_model

// file: verif/dual_comparator_control_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module dual_comparator_control_tb;
	import dcc_pkg::*;
	logic sys_clk = 1'h0;
	logic reset_n = 1'h0;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, speedSelectOut;
	logic [1:0] compareResultIn, compare_result_pin, compareResultOe, compareIrq;
	logic [1:0] windowModeOut, referenceSourceOut, comparatorEnableOut;
	logic [7:0] vin0 = 8'h00, vin1 = 8'h00, q;
	int n_fail = 0, num_checks = 0, cyc = 0;
	dcc_top dcc_top_i (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .compareResultIn, .compare_result_pin,
		.compareResultOe, .compareIrq, .windowModeOut, .referenceSourceOut,
		.comparatorEnableOut, .speedSelectOut);
	dcc_analog_model dcc_analog_model_i (.vin0, .vin1, .winMode(windowModeOut),
		.refSel(referenceSourceOut), .enable(comparatorEnableOut), .result(compareResultIn));
	initial forever #5 sys_clk = ~sys_clk;
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			n_fail++;
			end_of_test();
		end
	end
	task automatic wc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// a read right after a write to the same place sees the old value, so writes idle once
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		hsel <= 1'h1;
		do @(posedge sys_clk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge sys_clk); while (hreadyout !== 1'h1);
		q = hrdata[7:0];
		if (w) @(posedge sys_clk);
	endtask
	task automatic t_reset;
		bus(ADDR_PER_ENABLE, 1'h0, 8'h00); `CHK(q, RESET_BYTE)
		bus(ADDR_IRQ_MASK, 1'h0, 8'h00); `CHK(q, 8'hff)
		bus(ADDR_OUTCTL, 1'h1, 8'h83);
		bus(ADDR_OUTCTL, 1'h0, 8'h00); `CHK(q, RESET_BYTE)
		bus(8'h20, 1'h0, 8'h00); `CHK(q, 8'h00)
		`CHK(hresp, 1'h0)
	endtask
	task automatic t_setup;
		bus(ADDR_PER_ENABLE, 1'h1, 8'h20);
		bus(ADDR_OUTCTL, 1'h1, 8'h80);
		bus(ADDR_MODE, 1'h1, 8'h31);
		wc(10);
		bus(ADDR_FILTER, 1'h1, 8'h08);
		bus(ADDR_OUTCTL, 1'h1, 8'h83);
		bus(ADDR_IRQ_MASK, 1'h1, 8'hbf);
		bus(ADDR_IRQ_FLAG, 1'h1, 8'h00);
	endtask
	task automatic t_pin;
		vin0 <= 8'hc8;
		vin1 <= 8'h64;
		wc(8);
		`CHK({compareResultOe[0], compare_result_pin[0]}, 2'h3)
		bus(ADDR_MODE, 1'h0, 8'h00); `CHK({q[7], q[3]}, 2'h3)
		vin0 <= 8'h32;
		vin1 <= 8'hc8;
		wc(8);
		bus(ADDR_MODE, 1'h0, 8'h00); `CHK({q[7], q[3]}, 2'h0)
		bus(ADDR_OUTCTL, 1'h1, 8'h87);
		wc(3); `CHK(compare_result_pin[0], 1'h1)
		// interrupt enable off too, so the next rising edge must leave the flag clear
		bus(ADDR_OUTCTL, 1'h1, 8'h80);
		wc(3); `CHK({compareResultOe[0], compare_result_pin[0]}, 2'h0)
		bus(ADDR_IRQ_FLAG, 1'h1, 8'h00);
		vin0 <= 8'hc8;
		wc(8);
		bus(ADDR_IRQ_FLAG, 1'h0, 8'h00); `CHK(q[IRQ_BIT0], 1'h0)
		vin0 <= 8'h32;
		bus(ADDR_OUTCTL, 1'h1, 8'h83);
		bus(ADDR_IRQ_FLAG, 1'h1, 8'h00);
	endtask
	task automatic t_edges;
		logic [7:0] cfg [3] = '{8'h08, 8'h00, 8'h04};
		for (int e = 0; e < 3; e++) begin
			bus(ADDR_FILTER, 1'h1, cfg[e]);
			bus(ADDR_IRQ_FLAG, 1'h1, 8'h00);
			vin0 <= 8'hc8;
			wc(8);
			bus(ADDR_IRQ_FLAG, 1'h0, 8'h00); `CHK(q[IRQ_BIT0], e != 2)
			`CHK(compareIrq[0], e != 2)
			bus(ADDR_IRQ_FLAG, 1'h1, 8'h00);
			vin0 <= 8'h32;
			wc(8);
			bus(ADDR_IRQ_FLAG, 1'h0, 8'h00); `CHK(q[IRQ_BIT0], e != 1)
		end
	endtask
	task automatic t_filter;
		int dv [2] = '{FILT_DIV_MID, FILT_DIV_SLOW};
		bus(ADDR_FILTER, 1'h1, 8'h09);
		wc(8);
		bus(ADDR_IRQ_FLAG, 1'h1, 8'h00);
		vin0 <= 8'hc8;
		wc(FILT_MATCHES - 1);
		vin0 <= 8'h32;
		wc(12);
		bus(ADDR_IRQ_FLAG, 1'h0, 8'h00); `CHK(q[IRQ_BIT0], 1'h0)
		for (int i = 0; i < 2; i++) begin
			bus(ADDR_FILTER, 1'h1, 8'h0a + 8'(i));
			wc(4 * dv[i] + 4);
			bus(ADDR_IRQ_FLAG, 1'h1, 8'h00);
			vin0 <= (i == 0) ? 8'hc8 : 8'h32;
			wc(2 * dv[i]);
			bus(ADDR_IRQ_FLAG, 1'h0, 8'h00); `CHK(q[IRQ_BIT0], 1'h0)
			wc(3 * dv[i] + 8);
			bus(ADDR_IRQ_FLAG, 1'h0, 8'h00); `CHK(q[IRQ_BIT0], 1'h1)
		end
	endtask
	task automatic t_comp1;
		bus(ADDR_IRQ_PRIO, 1'h1, 8'h5a);
		bus(ADDR_IRQ_PRIO, 1'h0, 8'h00); `CHK(q, 8'h5a)
		// comparator 1 bypassed, both edges; comparator 0 settings untouched
		bus(ADDR_FILTER, 1'h1, 8'h8b);
		bus(ADDR_OUTCTL, 1'h1, 8'h8b);
		bus(ADDR_IRQ_MASK, 1'h1, 8'h3f);
		bus(ADDR_IRQ_FLAG, 1'h1, 8'h00);
		vin1 <= 8'h64;
		wc(8);
		bus(ADDR_IRQ_FLAG, 1'h0, 8'h00); `CHK(q[IRQ_BIT1:IRQ_BIT0], 2'h2)
		`CHK(compareIrq, 2'h2)
		// between the pin reference and the internal one
		vin0 <= 8'h6e;
		wc(8);
		bus(ADDR_RAW, 1'h0, 8'h00); `CHK(q[1:0], 2'h3)
		bus(ADDR_MODE, 1'h1, 8'h35);
		wc(4);
		bus(ADDR_RAW, 1'h0, 8'h00); `CHK(q[1:0], 2'h2)
	endtask
	task automatic t_stop;
		bus(ADDR_MODE, 1'h1, 8'h00);
		bus(ADDR_IRQ_FLAG, 1'h1, 8'h00);
		bus(ADDR_PER_ENABLE, 1'h1, 8'h00);
		bus(ADDR_OUTCTL, 1'h1, 8'h83);
		bus(ADDR_OUTCTL, 1'h0, 8'h00); `CHK(q, 8'h00)
		`CHK({compareResultOe, speedSelectOut}, 3'h0)
		bus(ADDR_PER_ENABLE, 1'h1, 8'h20);
		bus(ADDR_FILTER, 1'h0, 8'h00); `CHK(q, 8'h00)
		bus(ADDR_MODE, 1'h1, 8'h88);
		bus(ADDR_MODE, 1'h0, 8'h00); `CHK(q, 8'h00)
	endtask
	initial begin
		wc(20);
		reset_n <= 1'h1;
		wc(1);
		t_reset();
		t_setup();
		t_pin();
		t_edges();
		t_filter();
		t_comp1();
		t_stop();
		end_of_test();
	end
endmodule // dual_comparator_control_tb
